// ---- src/pep_cfg.svh ----
// Register offsets, field positions and reset values of the peripheral enable/priority block
`ifndef PEP_CFG_SVH
`define PEP_CFG_SVH
`define PEP_IDX_EN4 12'hf8e
`define PEP_IDX_EN5 12'hf91
`define PEP_IDX_PR1 12'hf9f
`define PEP_IDX_EN2 12'hfa0
`define PEP_IDX_PR2 12'hfa2
`define PEP_IDX_EN3 12'hfa3
`define PEP_IDX_PR3 12'hfa5
`define PEP_IDX_CTRL 12'hfd0
`define PEP_ADDR_W 14
`define PEP_EN_RST 8'h00
`define PEP_PR_RST 8'hff
`define PEP_EN2_MASK 8'hef
`define PEP_EN5_MASK 8'h3f
`define PEP_PR2_MASK 8'hef
`define PEP_FULL_MASK 8'hff
`define PEP_PR1_28PIN_MASK 8'h7f
`define PEP_CTRL_PRIO_BIT 7
`define PEP_CTRL_PERI_BIT 6
`define PEP_CTRL_MASK 8'hc0
`define PEP_RESP_OKAY 2'b00
`define PEP_RESP_SLVERR 2'b10
`define PEP_NSETS 7
`endif

// ---- src/pep_pkg.sv ----
// Types shared by the peripheral enable/priority block
package pep_pkg;
   typedef struct packed {
      logic [7:0] en2;
      logic [7:0] en3;
      logic [7:0] en4;
      logic [7:0] en5;
   } pep_flags_t;
   typedef struct packed {
      logic high;
      logic low;
   } pep_req_t;
   typedef enum logic [2:0] {
      PEP_SEL_EN2, PEP_SEL_EN3, PEP_SEL_EN4, PEP_SEL_EN5,
      PEP_SEL_PR1, PEP_SEL_PR2, PEP_SEL_PR3, PEP_SEL_NONE
   } pep_sel_t;
endpackage

// ---- src/pep_route.sv ----
// Per-source request routing to the high and low priority lines
`timescale 1ns/1ps
`default_nettype none
module pep_route (
   input wire logic [7:0] flag,   // Source flags
   input wire logic [7:0] enable, // Source enables
   input wire logic [7:0] prio,   // Source priorities
   output logic [7:0] reqHigh,    // Requests on high level
   output logic [7:0] reqLow      // Requests on low level
);
   wire [7:0] active = flag & enable; // RULE14
   assign reqHigh = active & prio; // RULE14
   assign reqLow = active & ~prio; // RULE14
endmodule
`default_nettype wire

// ---- src/pep_top.sv ----
// AXI4-Lite register file and request gating for peripheral enables and priorities
`include "pep_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: Enable set two, bit 4 reads zero
// RULE2: Enable set three, eight serial/timer/calendar sources
// RULE3: Enable set four, capture units ten to three
// RULE4: Enable set five, bits 7-6 read zero
// RULE5: Enable bits read/write, one permits, reset zero
// RULE6: Priority bits matter only with levels on
// RULE7: Priority bits read/write, one high, reset one
// RULE8: Priority set one, eight legacy sources
// RULE9: 28-pin parts lack parallel-port priority bit
// RULE10: Priority set two like enable two, bit4 zero
// RULE11: Priority set three ordered like enable three
// RULE12: Levels off needs peripheral global enable
// RULE13: Levels-on bit resets zero, zero means single
// RULE14: Flag and enable raise request at priority
// RULE15: Unimplemented bits ignore writes, read zero
module pep_top #(
   parameter bit PIN28 = 1'b0           // Small package variant
) (
   input wire logic clk_sys,            // 10 MHz system clock
   input wire logic nrst,               // Async reset, active low
   input wire logic [13:0] awaddr,      // Write address
   input wire logic awvalid,            // Write address valid
   output logic awready,                // Write address ready
   input wire logic [31:0] wdata,       // Write data
   input wire logic [3:0] wstrb,        // Write strobes
   input wire logic wvalid,             // Write data valid
   output logic wready,                 // Write data ready
   output logic [1:0] bresp,            // Write response
   output logic bvalid,                 // Write response valid
   input wire logic bready,             // Write response ready
   input wire logic [13:0] araddr,      // Read address
   input wire logic arvalid,            // Read address valid
   output logic arready,                // Read address ready
   output logic [31:0] rdata,           // Read data
   output logic [1:0] rresp,            // Read response
   output logic rvalid,                 // Read data valid
   input wire logic rready,             // Read data ready
   input wire pep_pkg::pep_flags_t flags, // Peripheral flag bits
   input wire logic [7:0] flagSet1,     // Flags of priority set one sources
   output pep_pkg::pep_req_t irq,       // High and low requests
   output logic [7:0] levelsBits        // Control register image
);
   import pep_pkg::*;

   logic rstMeta, rstSync;
   // Every assertion below uses this clock and the synchronised reset
   default clocking cbSys @(posedge clk_sys);
   endclocking
   default disable iff (!rstSync);

   // Byte address is four times the register index
   function automatic logic [13:0] regAddr(input logic [11:0] idx);
      regAddr = {idx, 2'b00};
   endfunction

   function automatic pep_sel_t decode(input logic [13:0] a);
      unique case (a)
         regAddr(`PEP_IDX_EN2): decode = PEP_SEL_EN2;
         regAddr(`PEP_IDX_EN3): decode = PEP_SEL_EN3;
         regAddr(`PEP_IDX_EN4): decode = PEP_SEL_EN4;
         regAddr(`PEP_IDX_EN5): decode = PEP_SEL_EN5;
         regAddr(`PEP_IDX_PR1): decode = PEP_SEL_PR1;
         regAddr(`PEP_IDX_PR2): decode = PEP_SEL_PR2;
         regAddr(`PEP_IDX_PR3): decode = PEP_SEL_PR3;
         default: decode = PEP_SEL_NONE;
      endcase
   endfunction

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   logic [7:0] en2, en3, en4, en5, pr1, pr2, pr3, ctrl;
   logic awHeld, wHeld;
   logic [13:0] awAddrQ;
   logic [31:0] wDataQ;
   logic wStrbQ;

   // Address and data may arrive in either order; hold each until both
   wire awTake = awvalid && awready;
   wire wTake = wvalid && wready;
   wire haveAw = awHeld || awTake;
   wire haveW = wHeld || wTake;
   wire [13:0] curAw = awHeld ? awAddrQ : awaddr;
   wire [31:0] curW = wHeld ? wDataQ : wdata;
   wire curStrb = wHeld ? wStrbQ : wstrb[0];
   wire doWrite = haveAw && haveW && !bvalid;
   wire isCtrlW = curAw == regAddr(`PEP_IDX_CTRL);
   wire pep_sel_t wSel = decode(curAw);
   wire wHit = wSel != PEP_SEL_NONE || isCtrlW;
   wire wEn = doWrite && wHit && curStrb;
   wire [7:0] wByte = curW[7:0];
   // Constant, so the reset branch below loads constants only
   localparam logic [7:0] pr1Mask = PIN28 ? `PEP_PR1_28PIN_MASK : `PEP_FULL_MASK; // RULE9

   wire [7:0] next_en2 = wByte & `PEP_EN2_MASK; // RULE1 RULE15
   wire [7:0] next_en5 = wByte & `PEP_EN5_MASK; // RULE4 RULE15
   wire [7:0] next_pr1 = wByte & pr1Mask; // RULE8 RULE9
   wire [7:0] next_pr2 = wByte & `PEP_PR2_MASK; // RULE10 RULE15
   wire [7:0] next_ctrl = wByte & `PEP_CTRL_MASK;

   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrQ <= '0;
         wDataQ <= '0;
         wStrbQ <= 1'b0;
      end else begin
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
         end else begin
            if (awTake) awHeld <= 1'b1;
            if (wTake) wHeld <= 1'b1;
         end
         if (awTake) awAddrQ <= awaddr;
         if (wTake) begin
            wDataQ <= wdata;
            wStrbQ <= wstrb[0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `PEP_RESP_OKAY;
      end else begin
         awready <= !haveAw && !bvalid && !(awvalid && awready);
         wready <= !haveW && !bvalid && !(wvalid && wready);
         if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wHit ? `PEP_RESP_OKAY : `PEP_RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         en2 <= `PEP_EN_RST; // RULE5
         en3 <= `PEP_EN_RST; // RULE5
         en4 <= `PEP_EN_RST; // RULE5
         en5 <= `PEP_EN_RST; // RULE5
         pr1 <= `PEP_PR_RST & pr1Mask; // RULE7 RULE9
         pr2 <= `PEP_PR_RST & `PEP_PR2_MASK; // RULE7 RULE10
         pr3 <= `PEP_PR_RST; // RULE7
         ctrl <= '0; // RULE13
      end else if (wEn) begin
         if (isCtrlW) ctrl <= next_ctrl; // RULE13
         else begin
            unique case (wSel)
               PEP_SEL_EN2: en2 <= next_en2;
               PEP_SEL_EN3: en3 <= wByte; // RULE2
               PEP_SEL_EN4: en4 <= wByte; // RULE3
               PEP_SEL_EN5: en5 <= next_en5;
               PEP_SEL_PR1: pr1 <= next_pr1;
               PEP_SEL_PR2: pr2 <= next_pr2;
               PEP_SEL_PR3: pr3 <= wByte; // RULE11
               PEP_SEL_NONE: ;
            endcase
         end
      end
   end

   // Read channel: one cycle answer, no side effects
   wire arTake = arvalid && arready;
   wire pep_sel_t rSel = decode(araddr);
   wire rCtrl = araddr == regAddr(`PEP_IDX_CTRL);
   logic [7:0] rByte;
   always_comb begin
      unique case (rSel)
         PEP_SEL_EN2: rByte = en2;
         PEP_SEL_EN3: rByte = en3;
         PEP_SEL_EN4: rByte = en4;
         PEP_SEL_EN5: rByte = en5;
         PEP_SEL_PR1: rByte = pr1;
         PEP_SEL_PR2: rByte = pr2;
         PEP_SEL_PR3: rByte = pr3;
         PEP_SEL_NONE: rByte = rCtrl ? ctrl : 8'h00;
      endcase
   end
   wire rHit = rSel != PEP_SEL_NONE || rCtrl;

   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `PEP_RESP_OKAY;
      end else begin
         arready <= !rvalid && !arTake;
         if (arTake) begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, rByte}; // RULE15
            rresp <= rHit ? `PEP_RESP_OKAY : `PEP_RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // Request gating; set-one sources have no enable here and are always enabled, except bit 7 when PIN28 is set
   logic [7:0] hi2, lo2, hi3, lo3, hi4, lo4, hi5, lo5, hi1, lo1;
   pep_route uR1 (.flag(flagSet1), .enable(pr1Mask), .prio(pr1), .reqHigh(hi1), .reqLow(lo1));
   pep_route uR2 (.flag(flags.en2), .enable(en2), .prio(pr2), .reqHigh(hi2), .reqLow(lo2));
   pep_route uR3 (.flag(flags.en3), .enable(en3), .prio(pr3), .reqHigh(hi3), .reqLow(lo3));
   pep_route uR4 (.flag(flags.en4), .enable(en4), .prio(`PEP_PR_RST),
                  .reqHigh(hi4), .reqLow(lo4));
   pep_route uR5 (.flag(flags.en5), .enable(en5), .prio(`PEP_PR_RST),
                  .reqHigh(hi5), .reqLow(lo5));

   wire levelsOn = ctrl[`PEP_CTRL_PRIO_BIT];
   wire periOn = ctrl[`PEP_CTRL_PERI_BIT];
   wire anyHi = |{hi1, hi2, hi3, hi4, hi5};
   wire anyLo = |{lo1, lo2, lo3, lo4, lo5};
   // Levels off: everything goes out on one line, gated by global enable
   wire next_high = levelsOn ? anyHi : ((anyHi || anyLo) && periOn); // RULE6 RULE12
   wire next_low = levelsOn && anyLo; // RULE6

   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         irq <= '0;
         levelsBits <= '0;
      end else begin
         irq.high <= next_high;
         irq.low <= next_low;
         levelsBits <= ctrl;
      end
   end

   // Reset values hold at the first edge after release
   a_en_reset_zero: assert property ( // RULE5
      $rose(rstSync) |-> {en2, en3, en4, en5} == {4{`PEP_EN_RST}})
      else $error("enable reset value wrong");
   a_prio_reset_one: assert property ( // RULE7
      $rose(rstSync) |-> pr1 == (`PEP_PR_RST & pr1Mask) && pr3 == `PEP_PR_RST
         && pr2 == (`PEP_PR_RST & `PEP_PR2_MASK))
      else $error("priority reset value wrong");
   a_ctrl_reset_zero: assert property ( // RULE13
      $rose(rstSync) |-> ctrl == '0 && levelsBits == '0)
      else $error("levels enabled out of reset");
   // Register file: written bytes land, masked where bits are missing
   a_write_lands: assert property ( // RULE2
      (wEn && wSel == PEP_SEL_EN3) |=> en3 == $past(wByte))
      else $error("enable three write lost");
   a_en2_write: assert property ( // RULE1
      (wEn && wSel == PEP_SEL_EN2) |=> en2 == ($past(wByte) & `PEP_EN2_MASK))
      else $error("enable two write lost");
   a_en4_write: assert property ( // RULE3
      (wEn && wSel == PEP_SEL_EN4) |=> en4 == $past(wByte))
      else $error("enable four write lost");
   a_en5_write: assert property ( // RULE4
      (wEn && wSel == PEP_SEL_EN5) |=> en5 == ($past(wByte) & `PEP_EN5_MASK))
      else $error("enable five write lost");
   a_pr1_write: assert property ( // RULE8
      (wEn && wSel == PEP_SEL_PR1) |=> pr1 == ($past(wByte) & pr1Mask))
      else $error("priority one write lost");
   a_pr2_write: assert property ( // RULE10
      (wEn && wSel == PEP_SEL_PR2) |=> pr2 == ($past(wByte) & `PEP_PR2_MASK))
      else $error("priority two write lost");
   a_pr3_write: assert property ( // RULE11
      (wEn && wSel == PEP_SEL_PR3) |=> pr3 == $past(wByte))
      else $error("priority three write lost");
   a_strobe_guard: assert property ( // RULE5
      (doWrite && !curStrb) |=> $stable({en2, en3, en4, en5, pr1, pr2, pr3, ctrl}))
      else $error("write without strobe changed a register");
   // Missing bits never become one
   a_en2_bit4_zero: assert property ( // RULE15
      en2[4] == 1'b0 && pr2[4] == 1'b0)
      else $error("bit 4 set");
   a_en5_top_zero: assert property ( // RULE4
      en5[7:6] == 2'b00)
      else $error("enable five top bits set");
   a_ctrl_mask: assert property ( // RULE15
      (ctrl & ~`PEP_CTRL_MASK) == 8'h00)
      else $error("control spare bits set");
   a_pin28_prio: assert property ( // RULE9
      PIN28 |-> pr1[7] == 1'b0)
      else $error("parallel priority present");
   // Read side: one-cycle answer, upper bits zero
   a_read_resp: assert property ( // RULE15
      arTake |=> rvalid && rdata[31:8] == 24'h000000)
      else $error("bad read");
   a_pr2_read: assert property ( // RULE10
      (arTake && rSel == PEP_SEL_PR2) |=> (rdata[7:0] & ~`PEP_PR2_MASK) == 8'h00)
      else $error("priority two spare bit read as one");
   a_en5_read: assert property ( // RULE4
      (arTake && rSel == PEP_SEL_EN5) |=> (rdata[7:0] & ~`PEP_EN5_MASK) == 8'h00)
      else $error("enable five spare bits read as one");
   a_slverr_zero: assert property ( // RULE15
      (arTake && !rHit) |=> rdata == '0 && rresp == `PEP_RESP_SLVERR)
      else $error("unmapped read not refused");
   // No second request is taken while an answer is pending
   a_busy_no_ready: assert property (
      bvalid |-> !awready && !wready)
      else $error("write accepted while response pending");
   a_read_no_ready: assert property (
      rvalid |-> !arready)
      else $error("read accepted while data pending");
   // Request routing
   a_low_needs_levels: assert property ( // RULE6
      irq.low |-> $past(levelsOn))
      else $error("low request without levels");
   a_single_needs_glob: assert property ( // RULE12
      (irq.high && !$past(levelsOn)) |-> $past(periOn))
      else $error("request without global enable");
   a_blocked_quiet: assert property ( // RULE12
      (!levelsOn && !periOn) |=> !irq.high && !irq.low)
      else $error("request while peripherals masked");
   a_single_route: assert property ( // RULE6
      (!levelsOn && periOn && |(flagSet1 & pr1Mask)) |=> irq.high && !irq.low)
      else $error("single-level request missing");
   a_hi_route: assert property ( // RULE14
      (levelsOn && |(flags.en2 & en2 & pr2)) |=> irq.high)
      else $error("high request missing");
   a_low_route: assert property ( // RULE11
      (levelsOn && |(flags.en3 & en3 & ~pr3)) |=> irq.low)
      else $error("low request missing");
   a_set4_high: assert property ( // RULE3
      (levelsOn && |(flags.en4 & en4)) |=> irq.high)
      else $error("set four request missing");
   a_set5_high: assert property ( // RULE4
      (levelsOn && |(flags.en5 & en5)) |=> irq.high)
      else $error("set five request missing");
   a_idle_quiet: assert property ( // RULE14
      (flags == '0 && flagSet1 == '0) |=> !irq.high && !irq.low)
      else $error("request with no flag");
   a_level_image: assert property ( // RULE13
      levelsBits == $past(ctrl))
      else $error("control image stale");
   // Main scenarios
   c_write: cover property (doWrite && wHit);
   c_read: cover property (arTake && rHit);
   c_low: cover property (irq.low);
   c_strobe_off: cover property (doWrite && !curStrb);
   c_single: cover property (irq.high && !levelsOn);
endmodule
`default_nettype wire

// ---- bench/pep_src.sv ----
// Model of the peripheral flag sources driving level flags
`timescale 1ns/1ps
`default_nettype none
module pep_src (
   input wire logic clk_sys,           // System clock
   input wire logic nrst,              // Reset, active low
   input wire logic load,              // Take new levels
   input wire logic [39:0] value,      // Sets two to five, then set one
   output pep_pkg::pep_flags_t flags,  // Flags of sets two to five
   output logic [7:0] flagSet1         // Flags of set one
);
   import pep_pkg::*;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         flags <= '0;
         flagSet1 <= '0;
      end else if (load) begin
         {flags, flagSet1} <= value;
      end
   end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Random register and request routing test of the enable/priority block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pep_pkg::*;
   logic clk_sys, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, load;
   logic [13:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d, rdataSmall, dSmall;
   logic [39:0] fRand;
   int jRand;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [7:0] flagSet1, levelsBits, v;
   logic [39:0] value;
   pep_flags_t flags;
   pep_req_t irq;
   int failures = 0, n_compared = 0, cyc = 0, seed, k;
   // Order: en2 en3 en4 en5 pr1 pr2 pr3 control
   logic [13:0] addrT [8] = '{14'h3e80, 14'h3e8c, 14'h3e38, 14'h3e44,
      14'h3e7c, 14'h3e88, 14'h3e94, 14'h3f40};
   logic [7:0] maskT [8] = '{8'hef, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hef, 8'hff, 8'hc0};
   logic [7:0] rstT [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hef, 8'hff, 8'h00};
   logic [7:0] sh [8];

   pep_top #(.PIN28(1'b0)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .flags(flags), .flagSet1(flagSet1), .irq(irq),
      .levelsBits(levelsBits));
   pep_src i_src (.clk_sys(clk_sys), .nrst(nrst), .load(load), .value(value),
      .flags(flags), .flagSet1(flagSet1));
   // Small-package variant shares the bus; only its read data is watched
   pep_top #(.PIN28(1'b1)) i_dut_small (.clk_sys(clk_sys), .nrst(nrst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(), .bresp(), .bvalid(), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(), .rdata(rdataSmall), .rresp(), .rvalid(),
      .rready(rready), .flags(flags), .flagSet1(flagSet1), .irq(), .levelsBits());

   // Priority one loses its top bit on the small package
   function automatic logic [7:0] smallMask(input int i);
      return (i == 4) ? 8'h7f : 8'hff;
   endfunction

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic stop_test;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         $display("unexpected at %0t: run hung", $time);
         stop_test();
      end
   end

   task automatic chkData(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: data %h, want %h", $time, got, exp);
      end
   endtask
   task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: response %b, want %b", $time, got, exp);
      end
   endtask
   task automatic chkIrq(input pep_req_t got, input pep_req_t exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: requests %b, want %b", $time, got, exp);
      end
   endtask

   // Address and data offered together, each released once taken
   task automatic wr(input logic [13:0] a, input logic [7:0] dv);
      awaddr <= a;
      wdata <= {$random(seed)} & 32'hffffff00 | {24'h0, dv};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [13:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      r = rresp;
      d = rdata;
      dSmall = rdataSmall;
      rready <= 1'b0;
      @(posedge clk_sys);
   endtask

   function automatic pep_req_t expIrq(input logic [39:0] f);
      logic [7:0] s2, s3, s4, s5;
      pep_req_t q;
      s2 = f[39:32] & sh[0];
      s3 = f[31:24] & sh[1];
      s4 = f[23:16] & sh[2];
      s5 = f[15:8] & sh[3];
      if (!sh[7][7]) begin
         q.high = sh[7][6] & (|{f[7:0], s2, s3, s4, s5});
         q.low = 1'b0;
      end else begin
         q.high = |{f[7:0] & sh[4], s2 & sh[5], s3 & sh[6], s4, s5};
         q.low = |{f[7:0] & ~sh[4], s2 & ~sh[5], s3 & ~sh[6]};
      end
      return q;
   endfunction

   task automatic irqStep(input int j, input logic [7:0] nv, input logic [39:0] f);
      wr(addrT[j], nv);
      sh[j] = nv & maskT[j];
      value <= f;
      load <= 1'b1;
      @(posedge clk_sys);
      load <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chkIrq(irq, expIrq(f));
      chkData({24'h0, levelsBits}, {24'h0, sh[7]});
   endtask

   initial begin
      seed = 32'h51c0;
      {nrst, awvalid, wvalid, bready, arvalid, rready, load} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      value = '0;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         rd(addrT[i]);
         chkResp(r, 2'b00);
         chkData(d, {24'h0, rstT[i]});
         chkData(dSmall, {24'h0, rstT[i] & smallMask(i)});
      end
      for (int n = 0; n < 6; n++) begin
         for (int i = 0; i < 8; i++) begin
            v = (n == 0) ? 8'hff : (n == 1) ? 8'h00 : 8'($random(seed));
            wr(addrT[i], v);
            chkResp(r, 2'b00);
            sh[i] = v & maskT[i];
            rd(addrT[i]);
            chkData(d, {24'h0, sh[i]});
            chkData(dSmall, {24'h0, sh[i] & smallMask(i)});
         end
      end
      // Byte lane 0 off: the write is answered but changes nothing
      wstrb <= 4'he;
      wr(addrT[1], ~sh[1]);
      chkResp(r, 2'b00);
      wstrb <= 4'hf;
      rd(addrT[1]);
      chkData(d, {24'h0, sh[1]});
      wr(14'h0010, 8'hff);
      chkResp(r, 2'b10);
      rd(14'h0010);
      chkResp(r, 2'b10);
      chkData(d, 32'h0);
      irqStep(7, 8'h00, '1);
      irqStep(7, 8'h40, 40'h0000000001);
      irqStep(7, 8'hc0, 40'h0100000000);
      for (k = 0; k < 60; k++) begin
         jRand = {$random(seed)} % 8;
         v = 8'($random(seed));
         fRand = {8'($random(seed)), 32'($random(seed))};
         irqStep(jRand, v, fRand);
      end
      stop_test();
   end
endmodule
`default_nettype wire
